// ---- core/aopr_pin_router.sv ----
// Mode-dependent routing of the converter's shared data pins
`timescale 1ns/10ps
`default_nettype none
module aopr_pin_router (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire aopr_pkg::aopr_bus_t  bus,
  output logic [31:0]             rd_data,
  input  wire aopr_pkg::aopr_pins_t pins,
  output logic [aopr_pkg::DW-1:0] db_out,
  output logic [aopr_pkg::DW-1:0] db_oe,
  output logic                    ref_buffers_on
);
  import aopr_pkg::*;

  typedef struct packed {
    aopr_pins_t                 sy1;
    aopr_pins_t                 sy2;
    aopr_pins_t                 prv;
    aopr_state_t                fsm;
    logic [31:0]                ctrl;
    logic [NLANE-1:0][DW-1:0]   shreg;
    logic [NLANE-1:0][BCW-1:0]  bitcnt;
    logic [NLANE-1:0][CHW-1:0]  widx;
    logic [CFG_BITS-1:0]        cfg_sh;
    logic [CCW-1:0]             cfg_cnt;
    logic [CHW-1:0]             pidx;
    logic                       phalf;
    logic [3:0]                 gap;
    logic                       seen;
    logic                       too_fast;
    logic                       ref_on;
    logic [DW-1:0]              dout;
    logic [DW-1:0]              doe;
    logic [31:0]                rdata;
  } aopr_st_t;

  aopr_st_t                   s;
  aopr_st_t                   n;
  logic [NLANE-1:0][3:0]      lw;
  logic [NLANE-1:0][CHW-1:0]  mem_ra;
  logic [NLANE-1:0][DW-1:0]   mem_rd;
  logic                       mem_we;
  logic [CHW-1:0]             mem_wa;
  logic [DW-1:0]              mem_wd;
  logic                       serial;
  logic                       sw_cfg;
  logic                       selb;
  logic                       selc;
  logic                       casc_en;
  logic                       frame_start;
  logic                       frame_end;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       rd_rise;
  logic [CHW-1:0]             pidx_next;

  // --------------------------------------------------------------
  // Lane word lists
  // --------------------------------------------------------------
  // Returns {valid, channel} of the pos-th word a lane sends.
  function automatic logic [3:0] lane_word(input logic [1:0] lane,
                                           input logic [CHW-1:0] pos,
                                           input logic sb,
                                           input logic sc);
    logic [NCH-1:0] inc;
    logic [CHW-1:0] cnt;
    logic [3:0]     res;
    cnt = '0;
    res = '0;
    case (lane)
      2'h0: inc = {!sc && !sb, !sc, !sb, !sb, 2'h3};
      2'h1: inc = {!sc, 1'h0, 2'h3, 2'h0};
      default: inc = {2'h3, 4'h0};
    endcase
    for (int k = 0; k < NCH; k++) begin
      if (inc[k]) begin
        if (cnt == pos && !res[3]) begin
          res = {1'h1, CHW'(k)};
        end
        cnt = cnt + 3'h1;
      end
    end
    return res;
  endfunction

  // --------------------------------------------------------------
  // Synchronised pin view
  // --------------------------------------------------------------
  assign serial      = s.sy2.interface_select;
  assign sw_cfg      = s.sy2.config_source_select;
  assign selb        = s.sy2.db[PIN_LANE_B_SELECT];
  assign selc        = s.sy2.db[PIN_LANE_C_SELECT];
  assign casc_en     = s.sy2.db[PIN_BYTE_ORDER_CASC];
  assign frame_start = s.prv.frame_select_n && !s.sy2.frame_select_n;
  assign frame_end   = !s.prv.frame_select_n && s.sy2.frame_select_n;
  assign sclk_rise   = !s.prv.db[PIN_SER_CLK] && s.sy2.db[PIN_SER_CLK];
  assign sclk_fall   = s.prv.db[PIN_SER_CLK] && !s.sy2.db[PIN_SER_CLK];
  assign rd_rise     = !s.prv.read_strobe_n && s.sy2.read_strobe_n;
  assign pidx_next   = (s.pidx == CHW'(NCH - 1)) ? '0 : s.pidx + 3'h1;

  aopr_result_mem #(
    .DW    (DW),
    .DEPTH (NCH),
    .NRD   (NLANE),
    .AW    (CHW)
  ) u_mem (
    .clk     (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  always_comb begin
    n = s;
    n.sy1 = pins;
    n.sy2 = s.sy1;
    n.prv = s.sy2;
    n.rdata = '0;
    n.gap = (s.gap == 4'hf) ? s.gap : s.gap + 4'h1;
    mem_we = 1'h0;
    mem_wa = '0;
    mem_wd = '0;
    for (int l = 0; l < NLANE; l++) begin
      lw[l] = lane_word(2'(l), s.widx[l], selb, selc);
      mem_ra[l] = lw[l][CHW-1:0];
    end
    // Parallel readout borrows lane A's read port
    if (s.fsm == ST_PAR) begin
      mem_ra[0] = s.pidx;
    end

    // --------------------------------------------------------------
    // Register port
    // --------------------------------------------------------------
    if (bus.wr) begin
      if (bus.addr == REG_CONTROL) begin
        n.ctrl = bus.wdata;
      end
      if (bus.addr == REG_STATUS) begin
        n.too_fast = 1'h0;
      end
      if (bus.addr >= REG_RESULT0 && bus.addr < REG_RESULT_END && bus.addr[1:0] == 2'h0) begin
        mem_we = 1'h1;
        mem_wa = CHW'((bus.addr - REG_RESULT0) >> 2);
        mem_wd = bus.wdata[DW-1:0];
      end
    end
    if (bus.rd) begin
      case (bus.addr)
        REG_CONTROL: n.rdata = s.ctrl;
        REG_STATUS:  n.rdata = {22'h0, s.too_fast, s.ref_on, s.fsm,
                                serial, sw_cfg, selb, selc, casc_en};
        default:     n.rdata = '0;
      endcase
    end

    // --------------------------------------------------------------
    // Frame sequencing
    // --------------------------------------------------------------
    case (s.fsm)
      ST_IDLE: begin
        // The interface mode is taken once per frame; mid-frame changes to it are not followed
        if (frame_start) begin
          n.fsm = serial ? ST_SER : ST_PAR;
          n.pidx = '0;
          n.phalf = 1'h0;
          n.cfg_cnt = '0;
          n.seen = 1'h0;
          for (int l = 0; l < NLANE; l++) begin
            n.shreg[l] = lw[l][3] ? mem_rd[l] : '0;
            n.widx[l] = 3'h1;
            n.bitcnt[l] = '0;
          end
        end
      end
      ST_SER: begin
        if (frame_end) begin
          n.fsm = ST_IDLE;
          n.widx = '0;
          if (sw_cfg && s.cfg_cnt == CCW'(CFG_BITS)) begin
            n.ctrl = s.cfg_sh;
          end
        end else begin
          if (sclk_fall) begin
            for (int l = 0; l < NLANE; l++) begin
              // Once own words run out the lane forwards the upstream device
              n.shreg[l] = {s.shreg[l][DW-2:0],
                            casc_en && s.sy2.db[PIN_CASCADE_IN_A - l]};
              n.bitcnt[l] = s.bitcnt[l] + 4'h1;
              if (s.bitcnt[l] == BCW'(DW - 1) && lw[l][3]) begin
                n.shreg[l] = mem_rd[l];
                n.widx[l] = s.widx[l] + 3'h1;
              end
            end
            if (sw_cfg) begin
              n.cfg_sh = {s.cfg_sh[CFG_BITS-2:0], s.sy2.db[PIN_CONFIG_SERIAL_IN]};
              if (s.cfg_cnt != CCW'(CFG_BITS)) begin
                n.cfg_cnt = s.cfg_cnt + 6'h1;
              end
            end
          end
          // Flags a host clock above the limit; sampling jitter is one cycle
          if (sclk_rise) begin
            n.seen = 1'h1;
            n.gap = '0;
            if (s.seen && s.gap < 4'(SCLK_MIN_CYC - 1)) begin
              n.too_fast = 1'h1;
            end
          end
        end
      end
      ST_PAR: begin
        if (frame_end) begin
          n.fsm = ST_IDLE;
        end else if (rd_rise) begin
          if (!s.sy2.byte_mode || s.phalf) begin
            n.pidx = pidx_next;
          end
          n.phalf = s.sy2.byte_mode && !s.phalf;
        end
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    n.doe = '0;
    n.dout = '0;
    if (n.fsm == ST_SER) begin
      n.doe[PIN_RESULT_LANE_A]      = 1'h1;
      n.doe[PIN_RESULT_LANE_A + 1]  = selb;
      n.doe[PIN_RESULT_LANE_A + 2]  = selc;
      for (int l = 0; l < NLANE; l++) begin
        n.dout[PIN_RESULT_LANE_A + l] = n.doe[PIN_RESULT_LANE_A + l] && n.shreg[l][DW-1];
      end
    end
    if (n.fsm == ST_PAR && !s.sy2.read_strobe_n) begin
      if (s.sy2.byte_mode) begin
        n.doe = BYTE_OE;
        n.dout[DW-1:DW/2] = (casc_en ^ s.phalf) ? mem_rd[0][DW-1:DW/2]
                                               : mem_rd[0][DW/2-1:0];
      end else begin
        n.doe = '1;
        n.dout = mem_rd[0];
      end
    end

    // Reference buffers: pin in hardware serial mode, else control word
    if (serial && !sw_cfg) begin
      n.ref_on = !s.sy2.db[PIN_REF_BUFFER_ENABLE_N];
    end else begin
      n.ref_on = s.ctrl[REF_BUFFER_CTRL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.sy1.frame_select_n <= 1'h1;
      s.sy2.frame_select_n <= 1'h1;
      s.prv.frame_select_n <= 1'h1;
      // Strobe idles high; a low reset value would fake a rising edge
      s.sy1.read_strobe_n  <= 1'h1;
      s.sy2.read_strobe_n  <= 1'h1;
      s.prv.read_strobe_n  <= 1'h1;
    end else begin
      s <= n;
    end
  end

  assign rd_data        = s.rdata;
  assign db_out         = s.dout;
  assign db_oe          = s.doe;
  assign ref_buffers_on = s.ref_on;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_mode_select: assert property (
    (s.fsm == ST_IDLE && frame_start) |=> (s.fsm == ($past(serial) ? ST_SER : ST_PAR)))
    else $error("frame entered wrong interface mode");

  a_ref_pin_ctrl: assert property (
    (serial && !sw_cfg) |=> (s.ref_on == !$past(s.sy2.db[PIN_REF_BUFFER_ENABLE_N])))
    else $error("reference buffers do not follow enable pin");

  a_ref_soft_ctrl: assert property (
    (!(serial && !sw_cfg)) |=> (s.ref_on == $past(s.ctrl[REF_BUFFER_CTRL_BIT])))
    else $error("reference buffers do not follow control bit");

  a_config_load: assert property (
    (s.fsm == ST_SER && frame_end && sw_cfg && s.cfg_cnt == CCW'(CFG_BITS))
    |=> (s.ctrl == $past(s.cfg_sh)))
    else $error("serial configuration word not loaded");

  a_lane_c_drive: assert property (
    (s.fsm == ST_SER && $past(s.fsm) == ST_SER)
    |-> (s.doe[PIN_RESULT_LANE_A + 2] == $past(selc))
        && (s.dout[PIN_RESULT_LANE_A + 2] == ($past(selc) && s.shreg[2][DW-1])))
    else $error("lane C drive wrong");

  a_lane_b_drive: assert property (
    (s.fsm == ST_SER && $past(s.fsm) == ST_SER)
    |-> (s.doe[PIN_RESULT_LANE_A + 1] == $past(selb))
        && (s.dout[PIN_RESULT_LANE_A + 1] == ($past(selb) && s.shreg[1][DW-1])))
    else $error("lane B drive wrong");

  a_lane_b_append: assert property (
    (s.fsm == ST_SER && !frame_end && sclk_fall && s.bitcnt[1] == BCW'(DW - 1)
     && s.widx[1] == 3'h2 && selb && !selc)
    |-> (mem_ra[1] == CH_C1) ##1 (s.shreg[1] == $past(mem_rd[1])))
    else $error("second converter of pair C missing on lane B");

  a_lane_a_drive: assert property (
    (s.fsm == ST_SER && $past(s.fsm) == ST_SER)
    |-> s.doe[PIN_RESULT_LANE_A] && (s.dout[PIN_RESULT_LANE_A] == s.shreg[0][DW-1]))
    else $error("lane A not driven with its shift data");

  a_single_lane: assert property (
    (s.fsm == ST_SER && !frame_end && sclk_fall && s.bitcnt[0] == BCW'(DW - 1)
     && s.widx[0] == 3'h5 && !selb && !selc)
    |-> (mem_ra[0] == CH_C1) ##1 (s.shreg[0] == $past(mem_rd[0])))
    else $error("lane A does not carry the last channel");

  a_byte_order: assert property (
    (s.fsm == ST_PAR && !frame_end && !s.sy2.read_strobe_n && s.sy2.byte_mode
     && !s.phalf && casc_en)
    |=> (s.doe == BYTE_OE) && (s.dout[DW-1:DW/2] == $past(mem_rd[0][DW-1:DW/2])))
    else $error("high byte not presented first");

  a_cascade_in: assert property (
    (s.fsm == ST_SER && !frame_end && sclk_fall && casc_en && !lw[0][3])
    |=> (s.shreg[0][0] == $past(s.sy2.db[PIN_CASCADE_IN_A])))
    else $error("cascade input not shifted into lane A");

  c_serial_frame: cover property (s.fsm == ST_IDLE && frame_start && serial);
  c_byte_read:    cover property (s.fsm == ST_PAR && rd_rise && s.sy2.byte_mode && s.phalf);
  c_cascade:      cover property (s.fsm == ST_SER && sclk_fall && casc_en && !lw[0][3]);
  c_config_load:  cover property (s.fsm == ST_SER && frame_end && s.cfg_cnt == CCW'(CFG_BITS));
endmodule
`default_nettype wire

// ---- core/aopr_pkg.sv ----
// Shared constants and types for the ADC output pin routing block
package aopr_pkg;
  localparam int DW       = 16;
  localparam int BCW      = $clog2(DW);
  localparam int NCH      = 6;
  localparam int NLANE    = 3;
  localparam int CHW      = 3;
  localparam int CFG_BITS = 32;
  localparam int CCW      = $clog2(CFG_BITS) + 1;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0]  REG_CONTROL     = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_RESULT0     = 8'h10;
  localparam logic [7:0]  REG_RESULT_END  = 8'h28;
  localparam int          REF_BUFFER_CTRL_BIT = 24;

  // --------------------------------------------------------------
  // Data pin positions
  // --------------------------------------------------------------
  localparam int PIN_REF_BUFFER_ENABLE_N = 14;
  localparam int PIN_CONFIG_SERIAL_IN    = 13;
  localparam int PIN_RESULT_LANE_A       = 8;
  localparam int PIN_BYTE_ORDER_CASC     = 7;
  localparam int PIN_SER_CLK             = 6;
  localparam int PIN_CASCADE_IN_A        = 5;
  localparam int PIN_LANE_C_SELECT       = 2;
  localparam int PIN_LANE_B_SELECT       = 1;
  localparam logic [DW-1:0] BYTE_OE      = 16'hff00;

  // Channel order in result memory
  localparam logic [CHW-1:0] CH_A0 = 3'h0;
  localparam logic [CHW-1:0] CH_C1 = 3'h5;

  // --------------------------------------------------------------
  // Serial clock limit
  // --------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 125;
  localparam int SCLK_MAX_MHZ = 36;
  localparam int SCLK_MIN_CYC = (SYS_CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } aopr_bus_t;

  typedef struct packed {
    logic [DW-1:0] db;
    logic          interface_select;
    logic          config_source_select;
    logic          byte_mode;
    logic          frame_select_n;
    logic          read_strobe_n;
  } aopr_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PAR  = 3'h2,
    ST_SER  = 3'h4
  } aopr_state_t;
endpackage

// ---- core/aopr_result_mem.sv ----
// Conversion result store with one write port and registered read ports
`timescale 1ns/10ps
`default_nettype none
module aopr_result_mem #(
  parameter int DW    = 16,
  parameter int DEPTH = 6,
  parameter int NRD   = 3,
  parameter int AW    = 3
) (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [AW-1:0]            wr_addr,
  input  wire logic [DW-1:0]            wr_data,
  input  wire logic [NRD-1:0][AW-1:0]   rd_addr,
  output logic      [NRD-1:0][DW-1:0]   rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [NRD-1:0][DW-1:0]   rd;
  } aopr_mem_st_t;

  aopr_mem_st_t s;
  aopr_mem_st_t n;

  always_comb begin
    n = s;
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      n.mem[wr_addr] = wr_data;
    end
    for (int r = 0; r < NRD; r++) begin
      n.rd[r] = (int'(rd_addr[r]) < DEPTH) ? s.mem[rd_addr[r]] : '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign rd_data = s.rd;
endmodule
`default_nettype wire

// ---- sim/aopr_host_model.sv ----
// Host controller model: frames, serial clock, config bits and parallel reads
`timescale 1ns/10ps
`default_nettype none
module aopr_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] db_wire,
  input  wire logic [15:0] db_oe,
  output var  logic        frame_n,
  output var  logic        read_n,
  output var  logic        sclk,
  output var  logic        config_serial_in,
  output var  logic [95:0] cap_a,
  output var  logic [95:0] cap_b,
  output var  logic [95:0] cap_c,
  output var  logic [15:0] par_word,
  output var  logic [15:0] par_oe
);
  initial begin
    frame_n = 1'b1;
    read_n  = 1'b1;
    sclk    = 1'b0;
    config_serial_in     = 1'b0;
  end

  task automatic frame(input logic v);
    @(posedge sys_clk);
    frame_n <= v;
    repeat (6) @(posedge sys_clk);
  endtask

  // --------------------------------------------------------------
  // Serial frame
  // --------------------------------------------------------------
  // Clock stands low outside frames; half = 4 gives a 64 ns period
  task automatic serial_frame(input int nbits, input logic [31:0] cfg, input int half);
    logic [31:0] sh;
    sh = cfg;
    frame(1'b0);
    for (int i = 0; i < nbits; i++) begin
      sclk <= 1'b1;
      config_serial_in  <= sh[31];
      sh = {sh[30:0], 1'b0};
      repeat (half) @(posedge sys_clk);
      // Late in the high phase: lanes only move after the fall
      cap_a <= {cap_a[94:0], db_wire[8]};
      cap_b <= {cap_b[94:0], db_wire[9]};
      cap_c <= {cap_c[94:0], db_wire[10]};
      sclk  <= 1'b0;
      repeat (half) @(posedge sys_clk);
    end
    config_serial_in <= 1'b0;
    frame(1'b1);
  endtask

  // --------------------------------------------------------------
  // Parallel read
  // --------------------------------------------------------------
  task automatic par_read();
    read_n <= 1'b0;
    for (int k = 0; k < 20 && db_oe == 16'h0000; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    par_word <= db_wire;
    par_oe   <= db_oe;
    read_n   <= 1'b1;
    for (int k = 0; k < 20 && db_oe != 16'h0000; k++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/adc_output_pin_routing_bench.sv ----
// Self-checking bench for the data pin routing block
`timescale 1ns/10ps
`default_nettype none
module adc_output_pin_routing_bench;
  import aopr_pkg::*;
  logic          sys_clk, resetn, ifsel, cfgsrc, bytem, idle_tgl;
  logic          ref_buffers_on, frame_n, read_n, sclk, config_serial_in;
  aopr_bus_t     bus;
  aopr_pins_t    pins;
  logic [31:0]   rd_data, seed, rv, d;
  logic [DW-1:0] db_out, db_oe, db_wire, set_db;
  logic [95:0]   cap_a, cap_b, cap_c;
  logic [15:0]   par_word, par_oe;
  logic [15:0]   res [6];
  logic [2:0]    m;
  int            miscompares, checked;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) idle_tgl <= resetn ? ~idle_tgl : 1'b0;

  // Undriven pins toggle so a released lane never reads as stale data
  always_comb begin
    db_wire = (set_db & 16'h40be) | ({16{idle_tgl}} & ~16'h40be);
    db_wire[13] = config_serial_in;
    db_wire[6] = sclk;
    db_wire = (db_out & db_oe) | (db_wire & ~db_oe);
  end
  assign pins = {db_wire, ifsel, cfgsrc, bytem, frame_n, read_n};

  aopr_pin_router dut_u (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .bus            (bus),
    .rd_data        (rd_data),
    .pins           (pins),
    .db_out         (db_out),
    .db_oe          (db_oe),
    .ref_buffers_on (ref_buffers_on)
  );
  aopr_host_model host_u (
    .sys_clk  (sys_clk),
    .db_wire  (db_wire),
    .db_oe    (db_oe),
    .frame_n  (frame_n),
    .read_n   (read_n),
    .sclk     (sclk),
    .config_serial_in      (config_serial_in),
    .cap_a    (cap_a),
    .cap_b    (cap_b),
    .cap_c    (cap_c),
    .par_word (par_word),
    .par_oe   (par_oe)
  );

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [95:0] exp_lane(input int lane, input logic sb, input logic sc,
                                           input logic casc);
    logic [95:0] s;
    logic        take;
    int          n;
    s = '0;
    n = 0;
    for (int w = 0; w < 6; w++) begin
      case (lane)
        0: take = (w < 2) || (w < 4 && !sb) || (w == 4 && !sc) || (w == 5 && !sc && !sb);
        1: take = (w == 2 || w == 3) || (w == 5 && !sc);
        default: take = (w >= 4);
      endcase
      if (take) begin
        s[95 - 16 * n -: 16] = res[w];
        n++;
      end
    end
    for (int i = 16 * n; i < 96; i++) s[95 - i] = casc;
    return s;
  endfunction

  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= wd;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] rdv);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    rdv = rd_data;
  endtask

  task automatic set_mode(input logic i, input logic c, input logic b, input logic [15:0] p);
    @(posedge sys_clk);
    ifsel  <= i;
    cfgsrc <= c;
    bytem  <= b;
    set_db <= p;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    bus = '0;
    ifsel = 1'b1;
    cfgsrc = 1'b0;
    bytem = 1'b0;
    set_db = '0;
    miscompares = 0;
    checked = 0;
    seed = 32'h0000_87bf;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("oe_after_reset", db_oe, 16'h0000);
    check("ref_after_reset", ref_buffers_on, 1'b0);
    repeat (3) @(posedge sys_clk);
    for (int w = 0; w < 6; w++) begin
      seed = xorshift(seed);
      res[w] = (w == 0) ? 16'h8001 : seed[15:0];
      bus_write(REG_RESULT0 + 8'(4 * w), {16'h0000, res[w]});
    end
    seed = xorshift(seed);
    rv = seed | 32'h0100_0000;
    bus_write(REG_CONTROL, rv);
    bus_read(REG_CONTROL, d);
    check("control_readback", d, rv);
    @(posedge sys_clk);
    #1;
    check("rdata_idle", rd_data, 32'h0000_0000);
    bus_write(8'h80, 32'hffff_ffff);
    bus_read(8'h80, d);
    check("unmapped_read", d, 32'h0000_0000);
    // Lane selections 00, 01, 10, 11, then cascade with all lanes on
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 3'h7 : 3'(k);
      d = '0;
      d[14] = k[0];
      d[7] = m[2];
      d[5:3] = {3{m[2]}};
      d[2] = m[1];
      d[1] = m[0];
      set_mode(1'b1, 1'b0, 1'b0, d[15:0]);
      check("ref_hw_pin", ref_buffers_on, !d[14]);
      bus_read(REG_STATUS, rv);
      check("status_mode", rv[4:0], {2'b10, m[0], m[1], m[2]});
      host_u.serial_frame(96, 32'h0, 4);
      check("lane_a", cap_a, exp_lane(0, m[0], m[1], m[2]));
      if (m[0]) check("lane_b", cap_b, exp_lane(1, m[0], m[1], m[2]));
      if (m[1]) check("lane_c", cap_c, exp_lane(2, m[0], m[1], m[2]));
    end
    // Pin level opposes the control bit, which must win
    for (int k = 0; k < 2; k++) begin
      d = '0;
      d[14] = k[0];
      set_mode(1'b1, 1'b1, 1'b0, d[15:0]);
      seed = xorshift(seed);
      rv = seed;
      rv[24] = k[0];
      host_u.serial_frame(32, rv, 4);
      check("ref_sw_ctrl", ref_buffers_on, k[0]);
      bus_read(REG_CONTROL, d);
      check("sdi_control", d, rv);
    end
    // Seven reads wrap past the last channel
    set_mode(1'b0, 1'b0, 1'b0, 16'h0000);
    host_u.frame(1'b0);
    for (int r = 0; r < 7; r++) begin
      host_u.par_read();
      check("par_word", par_word, res[r % 6]);
      check("par_oe", par_oe, 16'hffff);
    end
    host_u.frame(1'b1);
    for (int k = 0; k < 2; k++) begin
      set_mode(1'b0, 1'b0, 1'b1, {8'h00, k[0], 7'h00});
      host_u.frame(1'b0);
      host_u.par_read();
      check("byte_first", par_word[15:8], k[0] ? res[0][15:8] : res[0][7:0]);
      check("byte_oe", par_oe, BYTE_OE);
      host_u.par_read();
      check("byte_second", par_word[15:8], k[0] ? res[0][7:0] : res[0][15:8]);
      host_u.frame(1'b1);
    end
    // Deliberately over the clock limit so the rate flag must trip
    set_mode(1'b1, 1'b0, 1'b0, 16'h0000);
    host_u.serial_frame(8, 32'h0, 1);
    bus_read(REG_STATUS, rv);
    check("sclk_fast_flag", rv[9], 1'b1);
    bus_write(REG_STATUS, 32'h0000_0000);
    bus_read(REG_STATUS, rv);
    check("sclk_rate_flag", rv[9], 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
